/* File: core/ecp_consts.svh */
`ifndef ECP_CONSTS_SVH
`define ECP_CONSTS_SVH
// ==========================================
// Modes, command byte layout, timing
`define ECP_MODE_SPP       3'h0
`define ECP_MODE_PS2       3'h1
`define ECP_MODE_PFIFO     3'h2
`define ECP_MODE_ECP       3'h3
`define ECP_CMD_KIND_BIT   7
`define ECP_FIFO_DEPTH     16
`define ECP_IRQ_PULSE_NS   200
`define ECP_CLK_PERIOD_NS  100
`define ECP_IRQ_PULSE_CYC  (`ECP_IRQ_PULSE_NS / `ECP_CLK_PERIOD_NS)
`define ECP_STROBE_CYC     2
`endif

/* File: core/ecp_fifo.sv */
// ==========================================
// Small queue with valid/ready on both sides
module ecp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic             flush_in,
  // Fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out,
  // Level
  output logic [$clog2(DEPTH+1)-1:0] level_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH+1);
  if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
    $error("ecp_fifo: bad size");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    rd_q, wr_q;
  logic [CW-1:0]    cnt_q;
  logic             push, pop;
  assign in_ready_out  = (cnt_q != CW'(DEPTH));
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out  = mem_q[rd_q];
  assign level_out     = cnt_q;
  assign push = in_valid_in && in_ready_out;
  assign pop  = out_valid_out && out_ready_in;
  always_ff @(posedge clk_in) begin
    if (reset_in || flush_in) begin
      rd_q  <= '0;
      wr_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data_in;
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      if (push && !pop) cnt_q <= cnt_q + 1'b1;
      else if (pop && !push) cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule : ecp_fifo

/* File: core/ecp_pkg.sv */
package ecp_pkg;
  // ==========================================
  // Queue entry: byte plus command flag
  typedef struct packed {
    logic       is_cmd;
    logic [7:0] data;
  } ecp_entry_s;
  typedef enum logic [2:0] {
    ECP_IDLE, ECP_FWD_SETUP, ECP_FWD_STROBE, ECP_FWD_WAIT, ECP_REV_WAIT, ECP_REV_ACK
  } ecp_link_e;
endpackage : ecp_pkg

/* File: core/ecp_port.sv */
`include "ecp_consts.svh"
module ecp_port #(
  parameter int DEPTH     = `ECP_FIFO_DEPTH,
  parameter int BUF_DEPTH = 4
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  // Configuration
  input  wire logic [2:0] mode_in,
  input  wire logic       direction_in,
  input  wire logic       dma_request_enable_in,
  input  wire logic       service_irq_mask_clr_in,
  input  wire logic       service_irq_mask_set_in,
  input  wire logic       fault_irq_enable_n_in,
  input  wire logic       acknowledge_irq_enable_in,
  input  wire logic [3:0] queue_level_setting_in,
  input  wire logic       terminate_req_in,
  // Host byte port
  input  wire logic       data_byte_fifo_port_wr_in,
  input  wire logic       command_byte_fifo_port_wr_in,
  input  wire logic [7:0] host_wdata_in,
  input  wire logic       data_byte_fifo_port_rd_in,
  output logic [7:0]      host_rdata_out,
  output logic            host_full_out,
  output logic            host_empty_out,
  // DMA
  output logic            port_dma_request_out,
  input  wire logic       port_dma_acknowledge_n_in,
  input  wire logic       dma_terminal_count_in,
  // Interrupt (open drain)
  output logic            port_irq_line_out,
  output logic            port_irq_line_oe_out,
  // Status
  output logic            service_irq_mask_out,
  output logic            terminate_ok_out,
  output logic            turnaround_req_out,
  // Cable
  input  wire logic [7:0] cable_data_in,
  output logic [7:0]      cable_data_out,
  output logic            cable_data_oe_out,
  output logic            host_clk_n_out,
  output logic            host_ack_out,
  output logic            ctrl_push_pull_out,
  input  wire logic       periph_clk_n_in,
  input  wire logic       periph_ack_in,
  input  wire logic       fault_n_in,
  input  wire logic       ack_n_in
);
  localparam int CW  = $clog2(DEPTH+1);
  localparam int PCW = 4;
  if (DEPTH != `ECP_FIFO_DEPTH || BUF_DEPTH < 2) begin : g_bad_size
    $error("ecp_port: unsupported sizes");
  end
  // ==========================================
  // State
  typedef struct packed {
    ecp_pkg::ecp_link_e     st;
    logic                   mask;
    logic [7:0]             rle;
    logic                   rle_pend;
    logic [7:0]             rep_byte;
    logic                   rep_act;
    logic [PCW-1:0]         pulse;
    logic [PCW-1:0]         tmr;
    logic [7:0]             rdata;
    logic                   hclk_n;
    logic                   hack;
    logic [7:0]             odata;
    logic                   fault_q, ack_q, nerr_q, pclk_q;
    logic [1:0]             s_pclk, s_pack, s_fault, s_ack;
    logic [7:0]             s1_dat, s2_dat;
  } ecp_state_s;
  ecp_state_s q, d;
  // Forward input queue in front of the cable link; back-pressure reaches host full flag
  ecp_pkg::ecp_entry_s buf_in, buf_out;
  logic buf_in_ready, buf_out_valid, buf_pop;
  logic [$clog2(BUF_DEPTH+1)-1:0] buf_lvl;
  logic fifo_on;
  assign fifo_on = (mode_in == `ECP_MODE_PFIFO) || (mode_in == `ECP_MODE_ECP);
  assign buf_in.is_cmd = command_byte_fifo_port_wr_in;
  assign buf_in.data   = host_wdata_in;
  ecp_fifo #(.WIDTH(9), .DEPTH(BUF_DEPTH)) u_buf (
    .clk_in        (clk_in),
    .reset_in      (reset_in),
    .flush_in      (!fifo_on),
    .in_valid_in   ((data_byte_fifo_port_wr_in || command_byte_fifo_port_wr_in)
                    && !direction_in),
    .in_ready_out  (buf_in_ready),
    .in_data_in    (buf_in),
    .out_valid_out (buf_out_valid),
    .out_ready_in  (buf_pop),
    .out_data_out  (buf_out),
    .level_out     (buf_lvl)
  );
  logic [CW:0] eff_thr, thr_bytes, held, free_sl;
  logic        cond, svc_evt, pulse_evt, fault_fall, ack_rise, err_en_fall;
  logic        host_rd, dma_ack;
  // Main store: every reverse data byte, expanded copies included, waits here for the host
  logic [7:0]    st_out;
  logic          st_in_ready, st_out_valid;
  logic [CW-1:0] st_lvl;
  ecp_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_store (
    .clk_in        (clk_in),
    .reset_in      (reset_in),
    .flush_in      (!fifo_on),
    .in_valid_in   (q.rep_act),
    .in_ready_out  (st_in_ready),
    .in_data_in    (q.rep_byte),
    .out_valid_out (st_out_valid),
    .out_ready_in  (host_rd),
    .out_data_out  (st_out),
    .level_out     (st_lvl)
  );
  always_comb begin
    d = q;
    // Two-flop synchronisers
    d.s_pclk  = {q.s_pclk[0], periph_clk_n_in};
    d.s_pack  = {q.s_pack[0], periph_ack_in};
    d.s_fault = {q.s_fault[0], fault_n_in};
    d.s_ack   = {q.s_ack[0], ack_n_in};
    d.s1_dat  = cable_data_in;
    d.s2_dat  = q.s1_dat;
    d.fault_q = q.s_fault[1];
    d.ack_q   = q.s_ack[1];
    d.pclk_q  = q.s_pclk[1];
    d.nerr_q  = fault_irq_enable_n_in;
    eff_thr   = (CW+1)'(queue_level_setting_in) + 1'b1;
    thr_bytes = (CW+1)'(DEPTH) - eff_thr;
    held      = (CW+1)'(st_lvl) + (CW+1)'(buf_lvl);
    free_sl   = (CW+1)'(DEPTH) - held;
    // One byte read per access, by I/O strobe or DMA acknowledge
    dma_ack = !port_dma_acknowledge_n_in && dma_request_enable_in;
    host_rd = (data_byte_fifo_port_rd_in || dma_ack) && direction_in && st_out_valid;
    buf_pop = 1'b0;
    if (host_rd) begin
      d.rdata = st_out;
    end
    // Service conditions; mask blocks all of them
    if (dma_request_enable_in)
      cond = dma_terminal_count_in && !port_dma_acknowledge_n_in;
    else if (!direction_in)
      cond = free_sl >= thr_bytes;
    else
      cond = held >= thr_bytes;
    svc_evt = fifo_on && !q.mask && cond;
    if (service_irq_mask_clr_in) d.mask = 1'b0;
    if (service_irq_mask_set_in) d.mask = 1'b1;
    if (svc_evt) d.mask = 1'b1;
    fault_fall  = q.fault_q && !q.s_fault[1] && !fault_irq_enable_n_in;
    err_en_fall = q.nerr_q && !fault_irq_enable_n_in && !q.s_fault[1];
    ack_rise    = !q.ack_q && q.s_ack[1] && acknowledge_irq_enable_in;
    pulse_evt   = svc_evt || fault_fall || err_en_fall || ack_rise;
    if (pulse_evt) d.pulse = PCW'(`ECP_IRQ_PULSE_CYC);
    else if (q.pulse != '0) d.pulse = q.pulse - 1'b1;
    // Link engine
    case (q.st)
      ecp_pkg::ECP_IDLE: begin
        d.hclk_n = 1'b1;
        if (mode_in == `ECP_MODE_ECP && !direction_in && buf_out_valid
            && !st_out_valid) begin
          buf_pop = 1'b1;
          d.odata = buf_out.data;
          d.hack  = !buf_out.is_cmd;
          d.st    = ecp_pkg::ECP_FWD_SETUP;
        end else if (mode_in == `ECP_MODE_ECP && direction_in
                     && st_in_ready && !q.rep_act) begin
          d.hack = 1'b1;
          d.st   = ecp_pkg::ECP_REV_WAIT;
        end
      end
      ecp_pkg::ECP_FWD_SETUP: begin
        d.hclk_n = 1'b0;
        d.tmr    = PCW'(`ECP_STROBE_CYC);
        d.st     = ecp_pkg::ECP_FWD_STROBE;
      end
      ecp_pkg::ECP_FWD_STROBE: begin
        if (q.tmr != '0) d.tmr = q.tmr - 1'b1;
        else if (!q.s_pclk[1]) d.st = ecp_pkg::ECP_FWD_WAIT;
      end
      ecp_pkg::ECP_FWD_WAIT: begin
        d.hclk_n = 1'b1;
        if (q.s_pclk[1] || mode_in != `ECP_MODE_ECP) d.st = ecp_pkg::ECP_IDLE;
      end
      ecp_pkg::ECP_REV_WAIT: begin
        if (mode_in != `ECP_MODE_ECP || !direction_in) begin
          d.hack = 1'b0;
          d.st   = ecp_pkg::ECP_IDLE;
        end else if (q.pclk_q && !q.s_pclk[1]) begin
          if (!q.s_pack[1]) begin
            if (!q.s2_dat[`ECP_CMD_KIND_BIT]) begin
              d.rle      = q.s2_dat;
              d.rle_pend = 1'b1;
            end
          end else begin
            d.rep_byte = q.s2_dat;
            d.rle      = q.rle_pend ? q.rle : 8'h00;
            d.rle_pend = 1'b0;
            d.rep_act  = 1'b1;
          end
          d.hack = 1'b0;
          d.st   = ecp_pkg::ECP_REV_ACK;
        end
      end
      ecp_pkg::ECP_REV_ACK: begin
        // Ready rises again only from idle, once the store has room
        if (q.s_pclk[1]) begin
          d.st = ecp_pkg::ECP_IDLE;
        end
      end
      default: d.st = ecp_pkg::ECP_IDLE;
    endcase
    // Expansion writes one copy per cycle; queue stalls the link meanwhile
    if (q.rep_act && st_in_ready) begin
      if (q.rle == 8'h00) d.rep_act = 1'b0;
      else d.rle = q.rle - 1'b1;
    end
    // Store is flushed outside the queue modes, so a pending run dies too
    if (!fifo_on) begin
      d.rep_act = 1'b0;
    end
  end
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      q        <= '0;
      q.st     <= ecp_pkg::ECP_IDLE;
      q.mask   <= 1'b1;
      q.hclk_n <= 1'b1;
      q.nerr_q <= 1'b1;
      q.fault_q <= 1'b1;
      q.s_fault <= 2'h3;
      // Pins idle high; matching reset values avoid a false edge after reset
      q.ack_q   <= 1'b1;
      q.s_ack   <= 2'h3;
      q.pclk_q  <= 1'b1;
      q.s_pclk  <= 2'h3;
    end else begin
      q <= d;
    end
  end
  // ==========================================
  // Outputs
  assign host_rdata_out       = q.rdata;
  assign host_full_out        = direction_in ? !st_in_ready : !buf_in_ready;
  assign host_empty_out       = direction_in ? !st_out_valid : !buf_out_valid;
  assign port_dma_request_out = dma_request_enable_in && !q.mask && fifo_on
                                && (direction_in ? st_out_valid : buf_in_ready);
  assign port_irq_line_out    = 1'b0;
  assign port_irq_line_oe_out = (q.pulse != '0);
  assign service_irq_mask_out = q.mask;
  // Leave only when forward and idle; reverse asks for turnaround first
  assign terminate_ok_out     = terminate_req_in && !direction_in
                                && q.st == ecp_pkg::ECP_IDLE;
  assign turnaround_req_out   = terminate_req_in && direction_in;
  assign cable_data_out       = q.odata;
  assign cable_data_oe_out    = !direction_in;
  assign host_clk_n_out       = q.hclk_n;
  assign host_ack_out         = q.hack;
  assign ctrl_push_pull_out   = (mode_in != `ECP_MODE_SPP);
endmodule : ecp_port

/* File: tb/ecp_periph_model.sv */
// ==========================================
// Behavioural ECP peripheral on the cable
module ecp_periph_model (
  // Clock and mode
  input  wire logic  clk_in,
  input  wire logic  direction_in,
  input  wire logic  slow_in,
  // Host strobes
  input  wire logic  host_clk_n_in,
  input  wire logic  host_ack_in,
  // Peripheral drive
  output logic       periph_clk_n_out,
  output logic       periph_ack_out,
  output logic [7:0] data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  ecp_pkg::ecp_entry_s tx_q[$];
  int                  gap;
  initial begin
    {periph_clk_n_out, periph_ack_out, data_out} = 10'h3FF;
    forever begin
      @(posedge clk_in);
      #1;
      gap = slow_in ? 5 : 1;
      if (!direction_in && !host_clk_n_in) begin
        repeat (gap) @(posedge clk_in);
        #1 periph_clk_n_out = 1'b0;
        while (!host_clk_n_in) @(posedge clk_in);
        #1 periph_clk_n_out = 1'b1;
      end else if (direction_in && host_ack_in && tx_q.size() != 0) begin
        {periph_ack_out, data_out} = {!tx_q[0].is_cmd, tx_q[0].data};
        repeat (gap) @(posedge clk_in);
        #1 periph_clk_n_out = 1'b0;
        while (host_ack_in) @(posedge clk_in);
        #1 periph_clk_n_out = 1'b1;
        void'(tx_q.pop_front());
        while (!host_ack_in) @(posedge clk_in);
        // Scrambled after release so a stale byte is never taken twice
        #1 data_out = ~data_out;
      end
    end
  end
endmodule : ecp_periph_model

/* File: tb/ecp_port_props.sv */
// ==========================================
// Port checks: irq pulse, mask, drivers
module ecp_port_props (
  // Clock and reset
  input wire logic       clk_in,
  input wire logic       reset_in,
  // Controls
  input wire logic [2:0] mode_in,
  input wire logic       direction_in,
  input wire logic       dma_request_enable_in,
  input wire logic       fault_irq_enable_n_in,
  input wire logic       acknowledge_irq_enable_in,
  input wire logic       port_dma_acknowledge_n_in,
  input wire logic       dma_terminal_count_in,
  input wire logic       fault_n_in,
  input wire logic       ack_n_in,
  // Outputs
  input wire logic       service_irq_mask_out,
  input wire logic       port_dma_request_out,
  input wire logic       port_irq_line_out,
  input wire logic       port_irq_line_oe_out,
  input wire logic       terminate_ok_out,
  input wire logic       ctrl_push_pull_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  property p_push_pull;
    ctrl_push_pull_out == (mode_in != 3'h0);
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("driver kind wrong");
  property p_dma_masked;
    service_irq_mask_out |-> !port_dma_request_out;
  endproperty
  a_dma_masked: assert property (p_dma_masked) else $error("dma while masked");
  property p_irq_pulse;
    $rose(port_irq_line_oe_out) |-> !port_irq_line_out ##1 port_irq_line_oe_out ##1 !port_irq_line_oe_out;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq pulse shape");
  property p_term_fwd;
    terminate_ok_out |-> !direction_in;
  endproperty
  a_term_fwd: assert property (p_term_fwd) else $error("terminate in reverse");
  property p_reset;
    $fell(reset_in) |-> service_irq_mask_out && !port_irq_line_oe_out;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state");
  property p_tc;
    !service_irq_mask_out && dma_request_enable_in && !port_dma_acknowledge_n_in
      && dma_terminal_count_in |-> ##[1:3] port_irq_line_oe_out;
  endproperty
  a_tc: assert property (p_tc) else $error("no irq on terminal count");
  property p_fault;
    !fault_irq_enable_n_in && $fell(fault_n_in) |-> ##[1:5] port_irq_line_oe_out;
  endproperty
  a_fault: assert property (p_fault) else $error("no irq on fault");
  property p_ack;
    acknowledge_irq_enable_in && $rose(ack_n_in) |-> ##[1:5] port_irq_line_oe_out;
  endproperty
  a_ack: assert property (p_ack) else $error("no irq on acknowledge");
endmodule : ecp_port_props
bind ecp_port ecp_port_props u_ecp_port_props (.*);

/* File: tb/ecp_port_tb.sv */
module ecp_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in = 1'b0, reset_in = 1'b1, slow, rd_d = 1'b0, saw_full = 1'b0;
  logic        direction_in, dma_request_enable_in, service_irq_mask_clr_in;
  logic        service_irq_mask_set_in, fault_irq_enable_n_in, acknowledge_irq_enable_in;
  logic        terminate_req_in, data_byte_fifo_port_wr_in, command_byte_fifo_port_wr_in;
  logic        data_byte_fifo_port_rd_in, port_dma_acknowledge_n_in, dma_terminal_count_in;
  logic        fault_n_in, ack_n_in, periph_clk_n_in, periph_ack_in, host_full_out;
  logic        host_empty_out, port_dma_request_out, port_irq_line_out, port_irq_line_oe_out;
  logic        service_irq_mask_out, terminate_ok_out, turnaround_req_out, cable_data_oe_out;
  logic        host_clk_n_out, host_ack_out, ctrl_push_pull_out;
  logic [2:0]  mode_in;
  logic [3:0]  queue_level_setting_in;
  logic [7:0]  host_wdata_in, host_rdata_out, cable_data_in, cable_data_out, periph_data, r;
  logic [8:0]  fwd_q[$], rd_q[$];
  logic [31:0] seed = 32'h126ABC9D;
  int          bad_count = 0, check_count = 0, irq_exp = 0;
  ecp_port u_ecp_port (.*);
  ecp_periph_model u_ecp_periph_model (.clk_in(clk_in), .direction_in(direction_in),
    .slow_in(slow), .host_clk_n_in(host_clk_n_out), .host_ack_in(host_ack_out),
    .periph_clk_n_out(periph_clk_n_in), .periph_ack_out(periph_ack_in), .data_out(periph_data));
  assign cable_data_in = cable_data_oe_out ? cable_data_out : periph_data;
  always #50 clk_in = ~clk_in;
  // ==========================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(8);
  endtask : pulse
  // Pulse is held across back-to-back writes and dropped only while full
  task automatic wr(input logic cmd, input logic [7:0] b);
    if (host_full_out) begin
      {command_byte_fifo_port_wr_in, data_byte_fifo_port_wr_in} = 2'b00;
      saw_full = 1'b1;
      while (host_full_out) tick(1);
    end
    {command_byte_fifo_port_wr_in, data_byte_fifo_port_wr_in, host_wdata_in} = {cmd, !cmd, b};
    fwd_q.push_back({cmd, b});
    tick(1);
  endtask : wr
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  // ==========================================
  // Monitors
  always @(negedge host_clk_n_out) begin
    if (!reset_in) chk("fwd byte", fwd_q.pop_front(), {!host_ack_out, cable_data_out});
  end
  // Sampled mid-cycle: a read counts only if the store was not empty at its edge
  always @(negedge clk_in) begin
    if (rd_d) chk("rev byte", rd_q.pop_front(), {1'b0, host_rdata_out});
    rd_d <= data_byte_fifo_port_rd_in && !host_empty_out;
  end
  always @(posedge port_irq_line_oe_out) begin
    chk("irq expected", 9'h001, {8'h00, irq_exp > 0});
    irq_exp--;
  end
  initial begin
    #(2_000_000);
    bad_count++;
    $display("ERROR watchdog expected done seen hang");
    end_sim();
  end
  // ==========================================
  // Sequence
  initial begin
    {direction_in, dma_request_enable_in, service_irq_mask_clr_in, service_irq_mask_set_in,
     acknowledge_irq_enable_in, terminate_req_in, data_byte_fifo_port_wr_in,
     command_byte_fifo_port_wr_in, data_byte_fifo_port_rd_in, dma_terminal_count_in} = '0;
    {fault_irq_enable_n_in, port_dma_acknowledge_n_in, fault_n_in, ack_n_in, slow} = '1;
    {mode_in, queue_level_setting_in, host_wdata_in} = '0;
    tick(20);
    reset_in = 1'b0;
    tick(1);
    chk("mask", 1, service_irq_mask_out);
    chk("empty", 1, host_empty_out);
    for (int m = 0; m < 4; m++) begin
      mode_in = m[2:0];
      tick(1);
      chk("push pull", m != 0, ctrl_push_pull_out);
    end
    $display("test reset done");
    for (int i = 0; i < 10; i++) begin
      r = 8'(rnd());
      if (i == 0) r = {1'b0, r[6:1], 1'b1};
      wr(i == 0 || i == 3, i == 3 ? {1'b1, r[6:0]} : r);
    end
    {command_byte_fifo_port_wr_in, data_byte_fifo_port_wr_in} = 2'b00;
    while (fwd_q.size() != 0) tick(1);
    chk("full seen", 1, saw_full);
    terminate_req_in = 1'b1;
    tick(20);
    chk("terminate ok", 2'b10, {terminate_ok_out, turnaround_req_out});
    terminate_req_in = 1'b0;
    slow = 1'b0;
    queue_level_setting_in = 4'hF;
    irq_exp++;
    pulse(service_irq_mask_clr_in);
    chk("mask auto set", 9'h001, {irq_exp[7:0], service_irq_mask_out});
    pulse(service_irq_mask_set_in);
    $display("test forward done");
    mode_in = 3'h1;
    tick(1);
    direction_in = 1'b1;
    tick(1);
    mode_in = 3'h3;
    queue_level_setting_in = 4'hA;
    terminate_req_in = 1'b1;
    tick(4);
    chk("turnaround", 2'b01, {terminate_ok_out, turnaround_req_out});
    terminate_req_in = 1'b0;
    irq_exp++;
    pulse(service_irq_mask_clr_in);
    u_ecp_periph_model.tx_q = '{9'h103, 9'h0A5, 9'h03C, 9'h100, 9'h05A, 9'h10F, 9'h0C3};
    rd_q = '{9'h0A5, 9'h0A5, 9'h0A5, 9'h0A5, 9'h03C, 9'h05A};
    for (int i = 0; i < 16; i++) rd_q.push_back(9'h0C3);
    tick(200);
    chk("irq left", 0, irq_exp[8:0]);
    chk("full", 1, host_full_out);
    data_byte_fifo_port_rd_in = 1'b1;
    tick(24);
    data_byte_fifo_port_rd_in = 1'b0;
    tick(20);
    chk("drained", 9'h001, {rd_q.size() != 0, 7'h00, host_empty_out});
    $display("test reverse done");
    dma_request_enable_in = 1'b1;
    pulse(service_irq_mask_clr_in);
    chk("dma idle", 0, port_dma_request_out);
    {port_dma_acknowledge_n_in, dma_terminal_count_in} = 2'b01;
    irq_exp++;
    tick(1);
    {port_dma_acknowledge_n_in, dma_terminal_count_in} = 2'b10;
    tick(8);
    chk("tc irq", 9'h003, {irq_exp[6:0], service_irq_mask_out, !port_dma_request_out});
    $display("test dma done");
    fault_irq_enable_n_in = 1'b0;
    tick(4);
    irq_exp++;
    fault_n_in = 1'b0;
    tick(10);
    fault_n_in = 1'b1;
    fault_irq_enable_n_in = 1'b1;
    tick(6);
    fault_n_in = 1'b0;
    tick(10);
    irq_exp++;
    fault_irq_enable_n_in = 1'b0;
    tick(10);
    acknowledge_irq_enable_in = 1'b1;
    ack_n_in = 1'b0;
    tick(6);
    irq_exp++;
    ack_n_in = 1'b1;
    tick(10);
    chk("event irqs", 0, irq_exp[8:0]);
    mode_in = 3'h0;
    tick(3);
    chk("mode 000", 9'h001, {ctrl_push_pull_out, 7'h00, host_empty_out});
    $display("test events done");
    end_sim();
  end
endmodule : ecp_port_tb
